// ===== logic/adc_channel_level_control.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_level_consts.vh"

module adc_channel_level_control (
    input wire ref_clk, // pixel sample clock
    input wire sys_rst, // async reset, high
    input wire reg_wr, // host register write strobe
    input wire [7:0] reg_addr, // host register subaddress
    input wire [7:0] reg_wdata, // host write data
    output reg [7:0] reg_rdata, // readback, one cycle after address
    input wire line_start, // one-cycle pulse at line start
    input wire ext_clamp, // external clamp pulse, high active
    input wire [9:0] adc_r, // red converted sample
    input wire [9:0] adc_g, // green converted sample
    input wire [9:0] adc_b, // blue converted sample
    input wire [7:0] fine_gain_code_r, // red fine gain
    input wire [7:0] fine_gain_code_g, // green fine gain
    input wire [7:0] fine_gain_code_b, // blue fine gain
    input wire [9:0] fine_offset_r, // red fine offset
    input wire [9:0] fine_offset_g, // green fine offset
    input wire [9:0] fine_offset_b, // blue fine offset
    input wire [3:0] coarse_gain_code_r, // red coarse gain
    input wire [3:0] coarse_gain_code_g, // green coarse gain
    input wire [3:0] coarse_gain_code_b, // blue coarse gain
    input wire [5:0] coarse_offset_r, // red coarse offset
    input wire [5:0] coarse_offset_g, // green coarse offset
    input wire [5:0] coarse_offset_b, // blue coarse offset
    output wire [9:0] pix_r, // red processed pixel
    output wire [9:0] pix_g, // green processed pixel
    output wire [9:0] pix_b, // blue processed pixel
    output wire [3:0] analog_gain_r, // red gain to analog stage
    output wire [3:0] analog_gain_g, // green gain to analog stage
    output wire [3:0] analog_gain_b, // blue gain to analog stage
    output wire [5:0] analog_offset_r, // red offset to analog stage
    output wire [5:0] analog_offset_g, // green offset to analog stage
    output wire [5:0] analog_offset_b, // blue offset to analog stage
    output reg [3:0] fine_clamp_on, // back-porch clamp active, r,g,b,slicer
    output reg [3:0] coarse_clamp_on, // sync-tip clamp active, r,g,b,slicer
    output reg [2:0] clamp_mid_level, // mid-level select r,g,b
    output reg [2:0] cm_offset_on, // 300 mV offset active r,g,b
    output reg [1:0] tip_filter_sel, // sync-tip filter cutoff
    output reg [4:0] slicer_threshold, // slicer threshold code
    output reg [7:0] route_sel_first, // input switch select, first
    output reg [7:0] route_sel_second, // input switch select, second
    output reg alc_pulse // level measure window
);

    // ----------------------------------------------------------------
    // host registers
    // ----------------------------------------------------------------
    reg [7:0] clamp_window_start_ff;
    reg [7:0] clamp_window_width_ff;
    reg [7:0] clamp_level_and_slicer_threshold_ff;
    reg [7:0] input_route_select_first_ff;
    reg [7:0] input_route_select_second_ff;
    reg [7:0] level_loop_enable_ff;
    reg [7:0] fine_clamp_control_ff;
    reg [7:0] level_pulse_position_ff;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clamp_window_start_ff <= `RST_CLAMP_START;
            clamp_window_width_ff <= `RST_CLAMP_WIDTH;
            clamp_level_and_slicer_threshold_ff <= `RST_CLAMP_LEVEL;
            input_route_select_first_ff <= `RST_ROUTE;
            input_route_select_second_ff <= `RST_ROUTE;
            level_loop_enable_ff <= `RST_LEVEL_LOOP;
            fine_clamp_control_ff <= `RST_FINE_CLAMP;
            level_pulse_position_ff <= `RST_LEVEL_POS;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_CLAMP_START: clamp_window_start_ff <= reg_wdata;
                `ADDR_CLAMP_WIDTH: clamp_window_width_ff <= reg_wdata;
                `ADDR_CLAMP_LEVEL: clamp_level_and_slicer_threshold_ff <= reg_wdata;
                `ADDR_ROUTE_FIRST: input_route_select_first_ff <= reg_wdata;
                `ADDR_ROUTE_SECOND: input_route_select_second_ff <= reg_wdata;
                `ADDR_LEVEL_LOOP: level_loop_enable_ff <= reg_wdata;
                `ADDR_FINE_CLAMP: fine_clamp_control_ff <= reg_wdata;
                `ADDR_LEVEL_POS: level_pulse_position_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // readback; unmapped subaddresses read zero
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `ADDR_CLAMP_START: reg_rdata <= clamp_window_start_ff;
                `ADDR_CLAMP_WIDTH: reg_rdata <= clamp_window_width_ff;
                `ADDR_CLAMP_LEVEL: reg_rdata <= clamp_level_and_slicer_threshold_ff;
                `ADDR_ROUTE_FIRST: reg_rdata <= input_route_select_first_ff;
                `ADDR_ROUTE_SECOND: reg_rdata <= input_route_select_second_ff;
                `ADDR_LEVEL_LOOP: reg_rdata <= level_loop_enable_ff;
                `ADDR_FINE_CLAMP: reg_rdata <= fine_clamp_control_ff;
                `ADDR_LEVEL_POS: reg_rdata <= level_pulse_position_ff;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // line timing: pixel counter, clamp window and level pulse
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_PULSE = 2'b10;

    reg [7:0] pix_cnt_ff;
    reg cnt_run_ff;
    reg ext_d_ff;
    reg [1:0] lvl_state_ff;
    reg [3:0] lvl_cnt_ff;
    wire ext_mode;
    wire ext_rise;
    wire [8:0] win_end;
    wire int_window;
    wire clamp_window;
    wire lvl_start;
    wire fc_en;
    wire alc_en;

    assign ext_mode = fine_clamp_control_ff[`FC_EXT_BIT];
    assign ext_rise = ext_clamp & ~ext_d_ff;
    assign win_end = {1'b0, clamp_window_start_ff} + {1'b0, clamp_window_width_ff};
    assign int_window = cnt_run_ff && (pix_cnt_ff >= clamp_window_start_ff)
                        && ({1'b0, pix_cnt_ff} < win_end);
    // external pulse both opens the window and starts the level pulse
    assign clamp_window = ext_mode ? ext_clamp : int_window;
    // register 31h has no say once the external pulse is in charge
    assign lvl_start = ext_mode ? ext_rise
                       : (cnt_run_ff && pix_cnt_ff == level_pulse_position_ff);
    assign fc_en = fine_clamp_control_ff[`FC_EN_BIT];
    assign alc_en = level_loop_enable_ff[`LOOP_EN_BIT];

    // counter saturates so a long line never re-fires the window
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pix_cnt_ff <= 8'h00;
            cnt_run_ff <= 1'b0;
            ext_d_ff <= 1'b0;
        end else begin
            ext_d_ff <= ext_clamp;
            if (line_start) begin
                pix_cnt_ff <= 8'h00;
                cnt_run_ff <= 1'b1;
            end else if (pix_cnt_ff == 8'hFF) begin
                cnt_run_ff <= 1'b0;
            end else if (cnt_run_ff) begin
                pix_cnt_ff <= pix_cnt_ff + 8'h01;
            end
        end
    end

    // level pulse lasts a fixed count so the averager sees whole groups
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvl_state_ff <= ST_IDLE;
            lvl_cnt_ff <= 4'h0;
            alc_pulse <= 1'b0;
        end else begin
            case (lvl_state_ff)
                ST_IDLE: begin
                    if (lvl_start) begin
                        lvl_state_ff <= ST_PULSE;
                        lvl_cnt_ff <= `LEVEL_PULSE_LEN - 4'h1;
                        alc_pulse <= 1'b1;
                    end
                end
                ST_PULSE: begin
                    if (lvl_cnt_ff == 4'h0) begin
                        lvl_state_ff <= ST_IDLE;
                        alc_pulse <= 1'b0;
                    end else begin
                        lvl_cnt_ff <= lvl_cnt_ff - 4'h1;
                    end
                end
                default: begin
                    lvl_state_ff <= ST_IDLE;
                    alc_pulse <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clamp controls and analog selections
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fine_clamp_on <= 4'h0;
            coarse_clamp_on <= 4'h0;
            clamp_mid_level <= 3'h0;
            cm_offset_on <= 3'h0;
            tip_filter_sel <= 2'h0;
            slicer_threshold <= 5'h00;
            route_sel_first <= 8'h00;
            route_sel_second <= 8'h00;
        end else begin
            // mode bit per restorer: one is back-porch, zero is sync-tip
            fine_clamp_on <= (clamp_window && fc_en)
                ? fine_clamp_control_ff[`FC_MODE_LSB+3:`FC_MODE_LSB]
                : 4'h0;
            coarse_clamp_on <= ~fine_clamp_control_ff[`FC_MODE_LSB+3:`FC_MODE_LSB];
            clamp_mid_level <= clamp_level_and_slicer_threshold_ff[2:0];
            cm_offset_on <= (fine_clamp_control_ff[`FC_CM_BIT] && fc_en)
                ? (~clamp_level_and_slicer_threshold_ff[2:0]
                   & fine_clamp_control_ff[`FC_MODE_LSB+2:`FC_MODE_LSB])
                : 3'h0;
            tip_filter_sel <= level_loop_enable_ff[`LOOP_FILT_LSB+1:`LOOP_FILT_LSB];
            slicer_threshold <= clamp_level_and_slicer_threshold_ff[7:3];
            route_sel_first <= input_route_select_first_ff;
            route_sel_second <= input_route_select_second_ff;
        end
    end

    // ----------------------------------------------------------------
    // three independent channels
    // ----------------------------------------------------------------
    chan_pixel_proc u_red (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_in(adc_r),
        .fine_gain_code(fine_gain_code_r),
        .fine_offset(fine_offset_r),
        .coarse_gain_code(coarse_gain_code_r),
        .coarse_offset(coarse_offset_r),
        .alc_en(alc_en),
        .alc_pulse(alc_pulse),
        .pix_out(pix_r),
        .coarse_gain_out(analog_gain_r),
        .coarse_offset_out(analog_offset_r)
    );

    chan_pixel_proc u_green (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_in(adc_g),
        .fine_gain_code(fine_gain_code_g),
        .fine_offset(fine_offset_g),
        .coarse_gain_code(coarse_gain_code_g),
        .coarse_offset(coarse_offset_g),
        .alc_en(alc_en),
        .alc_pulse(alc_pulse),
        .pix_out(pix_g),
        .coarse_gain_out(analog_gain_g),
        .coarse_offset_out(analog_offset_g)
    );

    chan_pixel_proc u_blue (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_in(adc_b),
        .fine_gain_code(fine_gain_code_b),
        .fine_offset(fine_offset_b),
        .coarse_gain_code(coarse_gain_code_b),
        .coarse_offset(coarse_offset_b),
        .alc_en(alc_en),
        .alc_pulse(alc_pulse),
        .pix_out(pix_b),
        .coarse_gain_out(analog_gain_b),
        .coarse_offset_out(analog_offset_b)
    );

endmodule // adc_channel_level_control

`default_nettype wire

// ===== logic/adc_level_consts.vh
// Functional notes
// - digital fine gain is one plus code over 256; code zero is unity
// - red, green and blue each keep their own fine gain code
// - each channel adds its own signed 10-bit fine offset, -512..+511
// - 4-bit coarse analog gain per channel, default code seven
// - signed 6-bit coarse offset per channel, applied before conversion
// - level loop averages pixels and steers level to the fine offset value
// - level loop switched on or off from register 26h
// - register 31h positions the level pulse only with internal timing
// - external clamp leading edge starts both fine clamp and level pulse
// - internal clamp window starts at 05h and lasts width from 06h
// - each restorer is sync-tip or back-porch; 10h low bits pick mid level
// - back-porch clamping only while its enable in 2Ah is set
// - bit seven of 2Ah adds 300 mV offset with bottom-level clamping
// - input routing follows host selections at 19h and 1Ah
// - sync-tip loop filter offers three cutoffs: 0.5, 1.7, 4.8 MHz
`ifndef ADC_LEVEL_CONSTS_VH
`define ADC_LEVEL_CONSTS_VH

// ----------------------------------------------------------------
// register subaddresses
// ----------------------------------------------------------------
`define ADDR_CLAMP_START 8'h05
`define ADDR_CLAMP_WIDTH 8'h06
`define ADDR_CLAMP_LEVEL 8'h10
`define ADDR_ROUTE_FIRST 8'h19
`define ADDR_ROUTE_SECOND 8'h1A
`define ADDR_LEVEL_LOOP 8'h26
`define ADDR_FINE_CLAMP 8'h2A
`define ADDR_LEVEL_POS 8'h31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CLAMP_START 8'h06
`define RST_CLAMP_WIDTH 8'h10
`define RST_CLAMP_LEVEL 8'h00
`define RST_ROUTE 8'h00
`define RST_LEVEL_LOOP 8'h00
`define RST_FINE_CLAMP 8'h00
`define RST_LEVEL_POS 8'h20
`define RST_COARSE_GAIN 4'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LOOP_EN_BIT 0
`define LOOP_FILT_LSB 1
`define FC_EN_BIT 0
`define FC_MODE_LSB 1
`define FC_EXT_BIT 6
`define FC_CM_BIT 7

// ----------------------------------------------------------------
// level loop timing and arithmetic
// ----------------------------------------------------------------
`define LEVEL_PULSE_LEN 4'h8
`define LEVEL_AVG_SHIFT 3
`define LEVEL_STEP_SHIFT 2
`define FULL_SCALE 10'h3FF

`endif

// ===== logic/chan_pixel_proc.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_level_consts.vh"

module chan_pixel_proc (
    input wire ref_clk, // pixel sample clock
    input wire sys_rst, // async reset, high
    input wire [9:0] sample_in, // converted sample
    input wire [7:0] fine_gain_code, // digital gain code
    input wire [9:0] fine_offset, // signed fine offset / level target
    input wire [3:0] coarse_gain_code, // analog gain code request
    input wire [5:0] coarse_offset, // analog offset request
    input wire alc_en, // level loop on
    input wire alc_pulse, // level measure window
    output reg [9:0] pix_out, // processed pixel
    output reg [3:0] coarse_gain_out, // gain code to analog stage
    output reg [5:0] coarse_offset_out // offset code to analog stage
);

    // ----------------------------------------------------------------
    // saturate a signed sum into unsigned 10 bits
    // ----------------------------------------------------------------
    function [9:0] sat10;
        input signed [13:0] v;
        begin
            if (v < 0)
                sat10 = 10'h000;
            else if (v > $signed({4'h0, `FULL_SCALE}))
                sat10 = `FULL_SCALE;
            else
                sat10 = v[9:0];
        end
    endfunction

    reg [10:0] gained_ff;
    reg signed [12:0] corr_ff;
    reg [13:0] acc_ff;
    reg pulse_d_ff;
    wire [18:0] product;
    wire signed [12:0] offs_ext;
    wire signed [12:0] avg;
    wire signed [12:0] err;
    wire signed [13:0] level_sum;

    // gain of (256 + code) / 256, never below unity
    assign product = sample_in * {1'b1, fine_gain_code};
    assign offs_ext = {{3{fine_offset[9]}}, fine_offset};
    assign avg = $signed({2'b00, acc_ff[13:`LEVEL_AVG_SHIFT]});
    assign err = offs_ext - (avg + corr_ff);
    // loop correction replaces the fixed offset while the loop is on
    assign level_sum = $signed({3'b000, gained_ff}) + {corr_ff[12], corr_ff};

    // ----------------------------------------------------------------
    // datapath: gain stage, then offset with clipping
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gained_ff <= 11'h000;
            pix_out <= 10'h000;
            coarse_gain_out <= `RST_COARSE_GAIN;
            coarse_offset_out <= 6'h00;
        end else begin
            gained_ff <= product[18:8];
            pix_out <= sat10(level_sum);
            coarse_gain_out <= coarse_gain_code;
            coarse_offset_out <= coarse_offset;
        end
    end

    // ----------------------------------------------------------------
    // level loop: average over the pulse, step a fraction of the error
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            corr_ff <= 13'h0000;
            acc_ff <= 14'h0000;
            pulse_d_ff <= 1'b0;
        end else begin
            pulse_d_ff <= alc_pulse;
            if (alc_pulse && !pulse_d_ff)
                acc_ff <= {3'b000, gained_ff};
            else if (alc_pulse)
                acc_ff <= acc_ff + {3'b000, gained_ff};
            // loop off: track the programmed offset so switching on is smooth
            if (!alc_en)
                corr_ff <= offs_ext;
            else if (pulse_d_ff && !alc_pulse)
                corr_ff <= corr_ff + (err >>> `LEVEL_STEP_SHIFT);
        end
    end

endmodule // chan_pixel_proc

`default_nettype wire

// ===== verif/video_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// video source side: line markers, clamp
// ----------------------------------------
module video_src_model (
    input wire logic ref_clk, // sample clock
    input wire logic lines_on, // emit line markers
    input wire logic ext_req, // ask for one external clamp
    output logic line_start, // one-cycle line marker
    output logic ext_clamp // external clamp pulse
);
    logic [6:0] pos_ff = 7'h00;
    logic [4:0] ext_ff = 5'h00;
    initial begin
        line_start = 1'h0;
        ext_clamp = 1'h0;
    end
    // 128-cycle lines; clamp kept long since it also starts the level pulse
    always @(posedge ref_clk) begin
        pos_ff <= pos_ff + 7'h01;
        line_start <= lines_on && pos_ff == 7'h00;
        ext_clamp <= ext_ff != 5'h00;
        if (ext_req && ext_ff == 5'h00)
            ext_ff <= 5'h10;
        else if (ext_ff != 5'h00)
            ext_ff <= ext_ff - 5'h01;
    end
endmodule // video_src_model
`default_nettype wire

// ===== verif/adc_channel_level_control_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module level_ctl_chk (
    input wire logic ref_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic reg_wr, // strobe
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // data
    input wire logic ext_clamp, // ext clamp
    input wire logic [3:0] coarse_gain_code_r, // gain in
    input wire logic [5:0] coarse_offset_g, // offset in
    input wire logic [3:0] analog_gain_r, // gain out
    input wire logic [5:0] analog_offset_g, // offset out
    input wire logic [3:0] fine_clamp_on, // fine
    input wire logic [3:0] coarse_clamp_on, // tip
    input wire logic [2:0] clamp_mid_level, // mid
    input wire logic [2:0] cm_offset_on, // offset
    input wire logic alc_pulse // level
);
    logic [7:0] fc_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // shadow of the clamp control register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            fc_ff <= 8'h00;
        else if (reg_wr && reg_addr == 8'h2a)
            fc_ff <= reg_wdata;
    end
    a_gain_follows: assert property (
        !$past(sys_rst) |-> analog_gain_r == $past(coarse_gain_code_r))
        else $error("gain copy");
    a_offset_follows: assert property (
        !$past(sys_rst) |-> analog_offset_g == $past(coarse_offset_g))
        else $error("offset copy");
    a_level_len: assert property (
        $rose(alc_pulse) |-> alc_pulse[*8] ##1 !alc_pulse)
        else $error("pulse length");
    a_ext_level_start: assert property (
        fc_ff[6] && $rose(ext_clamp) && !alc_pulse |=> alc_pulse)
        else $error("no level pulse");
    a_ext_fine_window: assert property (
        !$past(sys_rst) && $past(fc_ff[6]) |-> fine_clamp_on ==
        ({4{$past(ext_clamp) & $past(fc_ff[0])}} & $past(fc_ff[4:1])))
        else $error("fine clamp");
    a_tip_select: assert property (
        !$past(sys_rst) |-> coarse_clamp_on == ~$past(fc_ff[4:1]))
        else $error("tip select");
    a_clamp_exclusive: assert property (
        (fine_clamp_on & coarse_clamp_on) == 4'h0)
        else $error("clamp overlap");
    a_cm_bottom_only: assert property (
        cm_offset_on[0] |-> !clamp_mid_level[0])
        else $error("offset at mid");
    c_level: cover property ($rose(alc_pulse));
    c_ext: cover property (fc_ff[6] && $rose(ext_clamp));
    c_cm: cover property (cm_offset_on[0]);
endmodule // level_ctl_chk
bind adc_channel_level_control level_ctl_chk level_ctl_chk_inst (.*);
`default_nettype wire

// ===== verif/adc_channel_level_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_level_consts.vh"
module adc_channel_level_control_tb;
    logic ref_clk, sys_rst, reg_wr, line_start, ext_clamp, lines_on, ext_req, alc_pulse;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, route_sel_first, route_sel_second, d;
    logic [7:0] fine_gain_code_r, fine_gain_code_g, fine_gain_code_b;
    logic [9:0] adc_r, adc_g, adc_b, fine_offset_r, fine_offset_g, fine_offset_b;
    logic [9:0] pix_r, pix_g, pix_b;
    logic [3:0] coarse_gain_code_r, coarse_gain_code_g, coarse_gain_code_b;
    logic [3:0] analog_gain_r, analog_gain_g, analog_gain_b, fine_clamp_on, coarse_clamp_on;
    logic [5:0] coarse_offset_r, coarse_offset_g, coarse_offset_b;
    logic [5:0] analog_offset_r, analog_offset_g, analog_offset_b;
    logic [2:0] clamp_mid_level, cm_offset_on;
    logic [1:0] tip_filter_sel;
    logic [4:0] slicer_threshold;
    int fail_count = 0, compares = 0, f1, f2, l1, l2;
    adc_channel_level_control adc_channel_level_control_inst (.*);
    video_src_model video_src_model_inst (.*);
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic settle;
        repeat (4) @(negedge ref_clk);
    endtask
    // first high cycle and count over a line
    task automatic meas(input int sel, output int first, len);
        int n;
        first = 0;
        len = 0;
        @(negedge ref_clk);
        for (n = 0; line_start !== 1'h1 && n < 300; n++) @(negedge ref_clk);
        if (n >= 300) begin
            fail_count++;
            close_out();
        end
        for (int k = 0; k < 120; k++) begin
            @(negedge ref_clk);
            if ((sel ? alc_pulse : fine_clamp_on[0]) === 1'h1) begin
                if (len == 0) first = k;
                len++;
            end
        end
    endtask
    function automatic logic [9:0] px(input int a, input int c, input int o);
        int v = ((a * (256 + c)) >>> 8) + o;
        return (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : v[9:0];
    endfunction
    task automatic t_regs;
        logic [7:0] ra[8] = '{8'h05, 8'h06, 8'h10, 8'h19, 8'h1a, 8'h26, 8'h2a, 8'h31};
        logic [7:0] rv[8] = '{`RST_CLAMP_START, `RST_CLAMP_WIDTH, `RST_CLAMP_LEVEL,
            `RST_ROUTE, `RST_ROUTE, `RST_LEVEL_LOOP, `RST_FINE_CLAMP, `RST_LEVEL_POS};
        for (int i = 0; i < 8; i++) begin
            rd(ra[i]);
            chk(d, rv[i]);
            wr(ra[i], 8'hc3 ^ i[7:0]);
            rd(ra[i]);
            chk(d, 8'hc3 ^ i[7:0]);
        end
        chk(route_sel_first, 8'hc0);
        chk(route_sel_second, 8'hc7);
        wr(8'h7f, 8'hff);
        rd(8'h7f);
        chk(d, 8'h00);
        for (int i = 0; i < 8; i++) wr(ra[i], rv[i]);
        for (int k = 0; k < 3; k++) begin
            wr(8'h26, k[6:0] << 1);
            settle();
            chk(tip_filter_sel, k[1:0]);
        end
        wr(8'h10, 8'h2d);
        settle();
        chk({slicer_threshold, clamp_mid_level}, 8'h2d);
    endtask
    task automatic t_pixel;
        int a[5] = '{512, 1023, 256, 16, 768};
        int c[5] = '{0, 255, 128, 64, 16};
        int o[5] = '{0, 0, -512, 511, -5};
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            {adc_r, adc_g, adc_b} <= {3{a[i][9:0]}};
            {fine_gain_code_r, fine_gain_code_g, fine_gain_code_b} <= {c[i][7:0], 8'h00, c[i][7:0]};
            {fine_offset_r, fine_offset_g, fine_offset_b} <= {o[i][9:0], o[i][9:0], 10'h000};
            settle();
            chk(pix_r, px(a[i], c[i], o[i]));
            chk(pix_g, px(a[i], 0, o[i]));
            chk(pix_b, px(a[i], c[i], 0));
        end
    endtask
    task automatic t_clamp;
        wr(8'h2a, 8'h03);
        wr(8'h05, 8'h10);
        wr(8'h06, 8'h04);
        meas(0, f1, l1);
        chk(l1, 4);
        wr(8'h05, 8'h20);
        meas(0, f2, l2);
        chk(f2 - f1, 16);
        chk(coarse_clamp_on, 4'he);
        wr(8'h2a, 8'h02);
        meas(0, f1, l1);
        chk(l1, 0);
        wr(8'h10, 8'h00);
        wr(8'h2a, 8'h83);
        settle();
        chk(cm_offset_on, 3'h1);
        wr(8'h10, 8'h01);
        settle();
        chk(cm_offset_on, 3'h0);
    endtask
    task automatic t_alc;
        wr(8'h2a, 8'h00);
        wr(8'h31, 8'h30);
        meas(1, f1, l1);
        chk(l1, 8);
        wr(8'h31, 8'h40);
        meas(1, f2, l2);
        chk(f2 - f1, 16);
        wr(8'h2a, 8'h43);
        meas(1, f1, l1);
        chk(l1, 0);
        @(posedge ref_clk);
        ext_req <= 1'h1;
        @(posedge ref_clk);
        ext_req <= 1'h0;
        l1 = 0;
        l2 = 0;
        repeat (40) begin
            @(negedge ref_clk);
            l1 += alc_pulse;
            l2 += fine_clamp_on[0];
        end
        chk(l1, 8);
        chk(l2, 16);
    endtask
    task automatic t_loop;
        wr(8'h2a, 8'h00);
        wr(8'h05, 8'h10);
        wr(8'h31, 8'h20);
        @(posedge ref_clk);
        adc_g <= 10'h080;
        fine_gain_code_g <= 8'h00;
        fine_offset_g <= 10'h100;
        wr(8'h26, 8'h01);
        repeat (3840) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pix_g >= 10'h0fc && pix_g <= 10'h104, 1);
        wr(8'h26, 8'h00);
        settle();
        chk(pix_g, 10'h180);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, reg_wr, reg_addr, reg_wdata, lines_on, ext_req} = {1'h1, 19'h0_0000};
        {adc_r, adc_g, adc_b, fine_offset_r, fine_offset_g, fine_offset_b, fine_gain_code_r,
            fine_gain_code_g, fine_gain_code_b, coarse_gain_code_r, coarse_gain_code_g,
            coarse_gain_code_b, coarse_offset_r, coarse_offset_g, coarse_offset_b} = '0;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(analog_gain_r, `RST_COARSE_GAIN);
        @(posedge ref_clk);
        sys_rst <= 1'h0;
        lines_on <= 1'h1;
        {coarse_gain_code_r, coarse_gain_code_g, coarse_gain_code_b} <= 12'hf07;
        {coarse_offset_r, coarse_offset_g, coarse_offset_b} <= 18'h2_07c5;
        settle();
        chk({analog_gain_r, analog_gain_g, analog_gain_b}, 12'hf07);
        chk({analog_offset_r, analog_offset_g}, 12'h81f);
        chk(analog_offset_b, 6'h05);
        t_regs();
        t_pixel();
        t_clamp();
        t_alc();
        t_loop();
        close_out();
    end
endmodule // adc_channel_level_control_tb
`default_nettype wire
